/* File: mmp_pwm.v */
/*
  eight-channel pattern pwm: apb register slave, per-channel waveform engines
  (old, fifo, periodical memory and random modes) and a shared memory reader.
  assumes an apb master on sys_clk and a memory port on the same clock that
  answers each mem_req with a one-cycle mem_ack carrying mem_rdata.
*/
// Our own choice: the APB slave port.
// What this block does
// - eight channels play patterns from registers or memory
// - channel group at base plus offset plus channel times 0x40
// - old mode period is period_count plus one ticks, or plus two ticks when DIV_COUNT is 1
// - old mode high for duty_threshold plus one ticks per period
// - gap_duration guard interval between waveforms
// - repeat count zero runs until enable clears
// - periodical modes play repeat_count times, then stop
// - source select zero plays up to 64 pattern word bits
// - fifo last_bit_position marks last bit; zero plays low word
// - source select one fetches buffer0_length words at extended base
// - memory last_bit_position marks last bit of final word
// - random mode alternates buffer0 and buffer1
// - block clears a random buffer's valid flag when drained
// - invalid next buffer stops output and flags underflow
// - shared enable register, one bit per channel
// - control bit 15 old, 8 guard, 7 idle, 6 and 5 mode
// - pattern words are fifo data, else fetch buffer
// - valid register holds one bit per random buffer
`timescale 1ns/1ns
`include "mmp_pwm_consts.vh"

module mmp_pwm #(
  parameter DIV_COUNT = 1
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         mem_req,
  output reg  [35:0] mem_addr,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  output reg  [7:0]  pwm_out,
  output reg  [7:0]  pwm_underflow
);

  // address decode: {hit, channel, offset as seen inside channel 0}
  function [15:0] mmp_dec;
    input [11:0] a;
    reg   [11:0] rel;
    begin
      rel    = a - `MMP_OFF_FIRST;
      mmp_dec = {(a >= `MMP_OFF_FIRST) && (rel < `MMP_GROUP_SPAN) && (a[1:0] == 2'b00),
                 rel[8:6], {6'h00, rel[5:0]} + `MMP_OFF_FIRST};
    end
  endfunction

  // writable bits per register, reserved bits stay zero
  function [31:0] mmp_mask;
    input [11:0] loc;
    begin
      case (loc)
        `MMP_OFF_CTL:                          mmp_mask = `MMP_MASK_CTL;
        `MMP_OFF_HDUR, `MMP_OFF_LDUR, `MMP_OFF_GDUR,
        `MMP_OFF_B0LEN, `MMP_OFF_B1LEN, `MMP_OFF_REP: mmp_mask = `MMP_MASK_16;
        `MMP_OFF_PER, `MMP_OFF_THR:            mmp_mask = `MMP_MASK_13;
        `MMP_OFF_B0EXT:                        mmp_mask = `MMP_MASK_EXT;
        default:                               mmp_mask = `MMP_MASK_32;
      endcase
    end
  endfunction

  localparam [15:0] DIV_LAST = DIV_COUNT - 1;

  reg  [31:0] r_ctl   [0:7];
  reg  [31:0] r_hdur  [0:7];
  reg  [31:0] r_ldur  [0:7];
  reg  [31:0] r_gdur  [0:7];
  reg  [31:0] r_b0    [0:7];
  reg  [31:0] r_b0len [0:7];
  reg  [31:0] r_b1    [0:7];
  reg  [31:0] r_b1len [0:7];
  reg  [31:0] r_wlo   [0:7];
  reg  [31:0] r_whi   [0:7];
  reg  [31:0] r_rep   [0:7];
  reg  [31:0] r_per   [0:7];
  reg  [31:0] r_thr   [0:7];
  reg  [31:0] r_b0ext [0:7];
  reg  [7:0]  chan_en;
  reg  [15:0] div_cnt;
  reg         tick;
  reg         arb_busy;
  reg  [2:0]  arb_owner;
  reg  [2:0]  arb_rr;
  reg         pick_ok;
  reg  [2:0]  pick_idx;
  reg  [2:0]  scan_idx;
  reg  [31:0] rd_word;
  reg         rd_err;
  integer     k;
  integer     j;

  wire [15:0]  dec    = mmp_dec(paddr);
  wire         dhit   = dec[15];
  wire [2:0]   dch    = dec[14:12];
  wire [11:0]  dloc   = dec[11:0];
  wire         wr_go  = psel & penable & pready & pwrite;
  wire [31:0]  wr_val = pwdata & mmp_mask(dloc);
  wire [7:0]   want_flat;
  wire [287:0] addr_flat;
  wire [7:0]   out_flat;
  wire [7:0]   under_flat;
  wire [15:0]  valid_flat;
  wire [23:0]  stat_flat;

  // divided tick, one every DIV_COUNT sys_clk cycles; the source clock selector is outside this block
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end
    else
    begin
      tick    <= (div_cnt == DIV_LAST);
      div_cnt <= (div_cnt == DIV_LAST) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // apb handshake: zero-wait, answer registered in the setup cycle
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `MMP_RST_REG;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      prdata  <= (psel & ~penable) ? rd_word : `MMP_RST_REG;
    end
  end

  // read mux; unmapped addresses answer with pslverr and zero data
  always @*
  begin
    rd_word = `MMP_RST_REG;
    rd_err  = 1'b0;
    if (paddr == `MMP_OFF_ENABLE)
      rd_word = {24'h00_0000, chan_en};
    else if (dhit)
    begin
      case (dloc)
        `MMP_OFF_CTL:   rd_word = r_ctl[dch];
        `MMP_OFF_HDUR:  rd_word = r_hdur[dch];
        `MMP_OFF_LDUR:  rd_word = r_ldur[dch];
        `MMP_OFF_GDUR:  rd_word = r_gdur[dch];
        `MMP_OFF_B0:    rd_word = r_b0[dch];
        `MMP_OFF_B0LEN: rd_word = r_b0len[dch];
        `MMP_OFF_B1:    rd_word = r_b1[dch];
        `MMP_OFF_B1LEN: rd_word = r_b1len[dch];
        `MMP_OFF_WLO:   rd_word = r_wlo[dch];
        `MMP_OFF_WHI:   rd_word = r_whi[dch];
        `MMP_OFF_REP:   rd_word = r_rep[dch];
        `MMP_OFF_PER:   rd_word = r_per[dch];
        `MMP_OFF_THR:   rd_word = r_thr[dch];
        `MMP_OFF_STAT:  rd_word = {29'h0000_0000, stat_flat[dch*3 +: 3]};
        `MMP_OFF_VALID: rd_word = {30'h0000_0000, valid_flat[dch*2 +: 2]};
        `MMP_OFF_B0EXT: rd_word = r_b0ext[dch];
        default:        rd_err  = 1'b1;
      endcase
    end
    else
      rd_err = 1'b1;
  end

  // register writes; a fetched word lands in the low pattern word
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      chan_en <= `MMP_RST_EN;
      for (k = 0; k < `MMP_NUM_CH; k = k + 1)
      begin
        r_ctl[k]   <= `MMP_RST_REG;
        r_hdur[k]  <= `MMP_RST_REG;
        r_ldur[k]  <= `MMP_RST_REG;
        r_gdur[k]  <= `MMP_RST_REG;
        r_b0[k]    <= `MMP_RST_REG;
        r_b0len[k] <= `MMP_RST_REG;
        r_b1[k]    <= `MMP_RST_REG;
        r_b1len[k] <= `MMP_RST_REG;
        r_wlo[k]   <= `MMP_RST_REG;
        r_whi[k]   <= `MMP_RST_REG;
        r_rep[k]   <= `MMP_RST_REG;
        r_per[k]   <= `MMP_RST_REG;
        r_thr[k]   <= `MMP_RST_REG;
        r_b0ext[k] <= `MMP_RST_REG;
      end
    end
    else
    begin
      if (wr_go && paddr == `MMP_OFF_ENABLE)
        chan_en <= pwdata[7:0];
      if (wr_go && dhit)
      begin
        case (dloc)
          `MMP_OFF_CTL:   r_ctl[dch]   <= wr_val;
          `MMP_OFF_HDUR:  r_hdur[dch]  <= wr_val;
          `MMP_OFF_LDUR:  r_ldur[dch]  <= wr_val;
          `MMP_OFF_GDUR:  r_gdur[dch]  <= wr_val;
          `MMP_OFF_B0:    r_b0[dch]    <= wr_val;
          `MMP_OFF_B0LEN: r_b0len[dch] <= wr_val;
          `MMP_OFF_B1:    r_b1[dch]    <= wr_val;
          `MMP_OFF_B1LEN: r_b1len[dch] <= wr_val;
          `MMP_OFF_WLO:   r_wlo[dch]   <= wr_val;
          `MMP_OFF_WHI:   r_whi[dch]   <= wr_val;
          `MMP_OFF_REP:   r_rep[dch]   <= wr_val;
          `MMP_OFF_PER:   r_per[dch]   <= wr_val;
          `MMP_OFF_THR:   r_thr[dch]   <= wr_val;
          `MMP_OFF_B0EXT: r_b0ext[dch] <= wr_val;
          default:        ;
        endcase
      end
      // the fetch wins over a software write: in memory modes this word is ours
      if (arb_busy && mem_ack)
        r_wlo[arb_owner] <= mem_rdata;
    end
  end

  // round-robin pick among channels waiting for a word
  always @*
  begin
    pick_ok  = 1'b0;
    pick_idx = 3'd0;
    scan_idx = 3'd0;
    for (j = 0; j < `MMP_NUM_CH; j = j + 1)
    begin
      scan_idx = arb_rr + j[2:0];
      if (!pick_ok && want_flat[scan_idx])
      begin
        pick_ok  = 1'b1;
        pick_idx = scan_idx;
      end
    end
  end

  // one outstanding read at a time keeps the memory port trivial
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      arb_busy  <= 1'b0;
      arb_owner <= 3'd0;
      arb_rr    <= 3'd0;
      mem_req   <= 1'b0;
      mem_addr  <= 36'h0_0000_0000;
    end
    else if (arb_busy)
    begin
      if (mem_ack)
      begin
        arb_busy <= 1'b0;
        mem_req  <= 1'b0;
      end
    end
    else if (pick_ok)
    begin
      arb_busy  <= 1'b1;
      arb_owner <= pick_idx;
      arb_rr    <= pick_idx + 3'd1;
      mem_req   <= 1'b1;
      mem_addr  <= addr_flat[pick_idx*36 +: 36];
    end
  end

  // output pins come straight from flip-flops
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      pwm_out       <= 8'h00;
      pwm_underflow <= 8'h00;
    end
    else
    begin
      pwm_out       <= out_flat;
      pwm_underflow <= under_flat;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `MMP_NUM_CH; gi = gi + 1)
    begin : g_ch
      localparam [2:0] ME      = gi;
      localparam [4:0] S_IDLE  = 5'b00001;
      localparam [4:0] S_RUN   = 5'b00010;
      localparam [4:0] S_GAP   = 5'b00100;
      localparam [4:0] S_FETCH = 5'b01000;
      localparam [4:0] S_DONE  = 5'b10000;

      reg  [4:0]  state;
      reg  [12:0] per_cnt;
      reg  [15:0] dur_cnt;
      reg  [15:0] rep_left;
      reg  [15:0] words_left;
      reg  [15:0] word_ptr;
      reg  [5:0]  bit_idx;
      reg         buf_sel;
      reg  [1:0]  valid;
      reg         under;
      reg         out_r;
      reg         en_q;

      wire        en        = chan_en[gi];
      wire [31:0] ctl       = r_ctl[gi];
      wire        old_mode  = ctl[`MMP_CTL_OLD];
      wire        from_mem  = ctl[`MMP_CTL_SRC] & ~old_mode;
      wire        rnd       = from_mem & ctl[`MMP_CTL_MODE];
      wire [5:0]  pos       = ctl[`MMP_CTL_POS_HI:`MMP_CTL_POS_LO];
      wire [63:0] pat       = {r_whi[gi], r_wlo[gi]};
      wire        cur_bit   = from_mem ? r_wlo[gi][bit_idx[4:0]] : pat[bit_idx];
      wire [15:0] dur       = cur_bit ? r_hdur[gi][15:0] : r_ldur[gi][15:0];
      wire        last_word = (words_left <= 16'h0001);
      wire [5:0]  fifo_last = (pos == 6'd0) ? 6'd31 : pos;
      wire [5:0]  mem_last  = (last_word & ~rnd) ? {1'b0, pos[4:0]} : 6'd31;
      wire [5:0]  last_bit  = from_mem ? mem_last : fifo_last;
      wire        bit_end   = tick && ({1'b0, dur_cnt} + 17'h0_0001 >= {1'b0, dur});
      wire        word_end  = bit_end && (bit_idx == last_bit);
      wire        per_end   = tick && (per_cnt >= r_per[gi][12:0]);
      wire        gap_end   = tick && ({1'b0, dur_cnt} + 17'h0_0001 >= {1'b0, r_gdur[gi][15:0]});
      wire        wave_end  = old_mode ? per_end : (word_end && (!from_mem || (last_word && !rnd)));
      wire        wave_more = (r_rep[gi][15:0] == 16'h0000) || (rep_left > 16'h0001);
      wire        word_got  = arb_busy && mem_ack && (arb_owner == ME);
      wire [15:0] len_cur   = buf_sel ? r_b1len[gi][15:0] : r_b0len[gi][15:0];
      wire [15:0] len_oth   = buf_sel ? r_b0len[gi][15:0] : r_b1len[gi][15:0];
      wire [35:0] base_cur  = buf_sel ? {4'h0, r_b1[gi]} : {r_b0ext[gi][3:0], r_b0[gi]};
      wire        vwr       = wr_go && dhit && (dch == ME) && (dloc == `MMP_OFF_VALID);

      assign want_flat[gi]          = state[3];
      assign addr_flat[gi*36 +: 36] = base_cur + {18'h0_0000, word_ptr, 2'b00};
      assign out_flat[gi]           = out_r;
      assign under_flat[gi]         = under;
      assign valid_flat[gi*2 +: 2]  = valid;
      assign stat_flat[gi*3 +: 3]   = {state[4], en & ~state[4] & ~state[0], under};

      // channel engine; disabling forces idle from any state
      always @(posedge sys_clk)
      begin
        if (srst)
        begin
          state      <= S_IDLE;
          per_cnt    <= 13'h0000;
          dur_cnt    <= 16'h0000;
          rep_left   <= 16'h0000;
          words_left <= 16'h0000;
          word_ptr   <= 16'h0000;
          bit_idx    <= 6'd0;
          buf_sel    <= 1'b0;
          valid      <= `MMP_RST_VALID;
          under      <= 1'b0;
          out_r      <= 1'b0;
          en_q       <= 1'b0;
        end
        else
        begin
          en_q <= en;
          if (en && !en_q)
            under <= 1'b0;
          if (!en)
          begin
            state    <= S_IDLE;
            out_r    <= ctl[`MMP_CTL_IDLE];
            rep_left <= r_rep[gi][15:0];
            buf_sel  <= 1'b0;
          end
          else
          begin
            case (state)
              S_IDLE:
              begin
                per_cnt    <= 13'h0000;
                dur_cnt    <= 16'h0000;
                bit_idx    <= 6'd0;
                word_ptr   <= 16'h0000;
                words_left <= len_cur;
                if (rnd && !valid[buf_sel])
                begin
                  under <= 1'b1;
                  state <= S_DONE;
                end
                else
                  state <= from_mem ? S_FETCH : S_RUN;
              end
              S_FETCH:
              begin
                if (word_got)
                begin
                  state   <= S_RUN;
                  bit_idx <= 6'd0;
                  dur_cnt <= 16'h0000;
                end
              end
              S_RUN:
              begin
                if (old_mode)
                begin
                  if (tick)
                  begin
                    out_r   <= (per_cnt <= r_thr[gi][12:0]);
                    per_cnt <= per_end ? 13'h0000 : per_cnt + 13'h0001;
                  end
                end
                else
                begin
                  out_r <= cur_bit;
                  if (bit_end)
                  begin
                    dur_cnt <= 16'h0000;
                    if (!word_end)
                      bit_idx <= bit_idx + 6'd1;
                    else if (from_mem && !last_word)
                    begin
                      words_left <= words_left - 16'h0001;
                      word_ptr   <= word_ptr + 16'h0001;
                      state      <= S_FETCH;
                    end
                    else if (rnd)
                    begin
                      valid[buf_sel] <= 1'b0;
                      buf_sel        <= ~buf_sel;
                      word_ptr       <= 16'h0000;
                      words_left     <= len_oth;
                      if (valid[~buf_sel])
                        state <= S_FETCH;
                      else
                      begin
                        under <= 1'b1;
                        state <= S_DONE;
                      end
                    end
                  end
                  else if (tick)
                    dur_cnt <= dur_cnt + 16'h0001;
                end
                if (wave_end)
                begin
                  if (wave_more)
                  begin
                    if (r_rep[gi][15:0] != 16'h0000)
                      rep_left <= rep_left - 16'h0001;
                    dur_cnt <= 16'h0000;
                    state   <= (r_gdur[gi][15:0] == 16'h0000) ? S_IDLE : S_GAP;
                  end
                  else
                    state <= S_DONE;
                end
              end
              S_GAP:
              begin
                out_r <= ctl[`MMP_CTL_GUARD];
                if (gap_end)
                begin
                  dur_cnt <= 16'h0000;
                  state   <= S_IDLE;
                end
                else if (tick)
                  dur_cnt <= dur_cnt + 16'h0001;
              end
              S_DONE:
                out_r <= ctl[`MMP_CTL_IDLE];
              default:
                state <= S_IDLE;
            endcase
          end
          // a software write of the valid bits wins over the drain clear
          if (vwr)
            valid <= pwdata[1:0];
        end
      end
    end
  endgenerate

endmodule // mmp_pwm

/* File: mmp_pwm_consts.vh */
/*
  constants of the eight-channel pattern pwm: register offsets inside a
  channel group, control field positions, field widths and reset values.
  assumes it is included by bare name from the pwm design file.
*/
`ifndef MMP_PWM_CONSTS_VH
`define MMP_PWM_CONSTS_VH

// shared register and channel group layout (byte addresses)
`define MMP_OFF_ENABLE    12'h000
`define MMP_CH_STRIDE     12'h040
`define MMP_OFF_FIRST     12'h010
`define MMP_GROUP_SPAN    12'h200
`define MMP_NUM_CH        8

// per-channel offsets, added to the channel number times the stride
`define MMP_OFF_CTL       12'h010
`define MMP_OFF_HDUR      12'h014
`define MMP_OFF_LDUR      12'h018
`define MMP_OFF_GDUR      12'h01c
`define MMP_OFF_B0        12'h020
`define MMP_OFF_B0LEN     12'h024
`define MMP_OFF_B1        12'h028
`define MMP_OFF_B1LEN     12'h02c
`define MMP_OFF_WLO       12'h030
`define MMP_OFF_WHI       12'h034
`define MMP_OFF_REP       12'h038
`define MMP_OFF_PER       12'h03c
`define MMP_OFF_THR       12'h040
`define MMP_OFF_STAT      12'h044
`define MMP_OFF_VALID     12'h048
`define MMP_OFF_B0EXT     12'h04c

// channel_control fields
`define MMP_CTL_OLD       15
`define MMP_CTL_POS_HI    14
`define MMP_CTL_POS_LO    9
`define MMP_CTL_GUARD     8
`define MMP_CTL_IDLE      7
`define MMP_CTL_MODE      6
`define MMP_CTL_SRC       5

// writable bits of each register
`define MMP_MASK_CTL      32'h0000_ffe0
`define MMP_MASK_16       32'h0000_ffff
`define MMP_MASK_13       32'h0000_1fff
`define MMP_MASK_EXT      32'h0000_000f
`define MMP_MASK_32       32'hffff_ffff

// status bits of the per-channel status word
`define MMP_STAT_UNDER    0
`define MMP_STAT_BUSY     1
`define MMP_STAT_DONE     2

// reset values
`define MMP_RST_REG       32'h0000_0000
`define MMP_RST_EN        8'h00
`define MMP_RST_VALID     2'b00

`endif

/* File: mmp_pwm_sva.sv */
/*
  port-level checker for the eight-channel pattern pwm.
  assumes it is bound to mmp_pwm and sees only its ports, on sys_clk.
*/
`timescale 1ns/1ns
module mmp_pwm_sva (
  input wire        sys_clk,
  input wire        srst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        mem_req,
  input wire [35:0] mem_addr,
  input wire        mem_ack,
  input wire [31:0] mem_rdata,
  input wire [7:0]  pwm_out,
  input wire [7:0]  pwm_underflow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // register bus: zero wait states, one-cycle answer, errors on every address above the last group
  apb_zero_wait_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  err_unmapped_a: assert property (psel && !penable && paddr > 12'h20c |=> pslverr) else $error("no error");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside access");

  // fetch port: request held with a still address until answered, then dropped
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("request moved");
  mem_drop_a: assert property (mem_req && mem_ack |=> !mem_req) else $error("request kept after answer");
  mem_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00) else $error("fetch not word aligned");

  // reset leaves the pwm, underflow and fetch request outputs at their quiet level
  rst_quiet_a: assert property (disable iff (1'b0) srst |=> pwm_out == 8'h00 && pwm_underflow == 8'h00 && !mem_req)
    else $error("outputs not quiet after reset");

  cover property (mem_req && mem_ack);
  cover property (pslverr);
  cover property (|pwm_underflow);
endmodule // mmp_pwm_sva

bind mmp_pwm mmp_pwm_sva mmp_pwm_sva_i (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pwm_out(pwm_out),
  .pwm_underflow(pwm_underflow));

/* File: mmp_mem_model.sv */
/*
  behavioural system memory for the pwm fetch port.
  assumes one held request at a time; answers after lat idle cycles.
*/
`timescale 1ns/1ns
module mmp_mem_model (
  input  wire        sys_clk,
  input  wire        mem_req,
  input  wire [35:0] mem_addr,
  input  wire [7:0]  lat,
  output reg         mem_ack,
  output reg  [31:0] mem_rdata
);
  reg [7:0] wait_cnt;

  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    wait_cnt = 8'h00;
  end

  // word is its address with bit 0 set; toggles between answers
  always @(posedge sys_clk)
  begin
    mem_ack <= mem_req && !mem_ack && wait_cnt >= lat;
    mem_rdata <= (mem_req && !mem_ack && wait_cnt >= lat) ? (mem_addr[31:0] | 32'h0000_0001) : ~mem_rdata;
    wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 8'h01 : 8'h00;
  end
endmodule // mmp_mem_model

/* File: mmp_pwm_tb.sv */
/*
  self-checking bench for the pattern pwm: apb master tasks and one task per mode.
  assumes DIV_COUNT 1, so one tick is one sys_clk cycle.
*/
`timescale 1ns/1ns
`include "mmp_pwm_consts.vh"
module mmp_pwm_tb;
  reg         sys_clk = 1'b0;
  reg         srst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [7:0]  lat = 8'h00;
  wire [31:0] prdata;
  wire [31:0] mem_rdata;
  wire [35:0] mem_addr;
  wire [7:0]  pwm_out;
  wire [7:0]  pwm_underflow;
  wire        pready;
  wire        pslverr;
  wire        mem_req;
  wire        mem_ack;
  reg  [31:0] rq;
  reg         re;
  integer     n_mismatch = 0;
  integer     check_count = 0;
  integer     n1;
  integer     n2;

  mmp_pwm #(.DIV_COUNT(1)) mmp_pwm_i (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pwm_out(pwm_out),
    .pwm_underflow(pwm_underflow));
  mmp_mem_model mmp_mem_model_i (.sys_clk(sys_clk), .mem_req(mem_req), .mem_addr(mem_addr), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #2 sys_clk = ~sys_clk;

  // verdict and end of run
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input [127:0] nm, input [35:0] got, input [35:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task hang(input integer k);
    begin
      if (k >= 2000)
      begin
        chk("wait bound", 36'h0_0000_0000, 36'h0_0000_0001);
        stop_test;
      end
    end
  endtask

  // one apb transfer; request held until ready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && k < 2000)
      begin
        @(posedge sys_clk);
        k = k + 1;
      end
      hang(k);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  function [11:0] ra(input [2:0] ch, input [11:0] off);
    ra = off + ch * `MMP_CH_STRIDE;
  endfunction

  // next run length of level lvl
  task run_len(input integer ch, input lvl, output integer n);
    integer k;
    begin
      k = 0;
      n = 0;
      while (pwm_out[ch] !== lvl && k < 2000)
      begin
        @(posedge sys_clk);
        k = k + 1;
      end
      while (pwm_out[ch] === lvl && n < 2000)
      begin
        @(posedge sys_clk);
        n = n + 1;
      end
      hang(k > n ? k : n);
    end
  endtask

  // waits for a fresh fetch request
  task wait_req;
    integer k;
    begin
      k = 0;
      while (mem_req === 1'b1 && k < 2000)
      begin
        @(posedge sys_clk);
        k = k + 1;
      end
      while (mem_req !== 1'b1 && k < 2000)
      begin
        @(posedge sys_clk);
        k = k + 1;
      end
      hang(k);
    end
  endtask

  task t_regs;
    begin
      rd(`MMP_OFF_ENABLE);
      chk("enable rst", rq, 36'h0_0000_0000);
      wr(ra(3, `MMP_OFF_CTL), 32'hffff_ffff);
      rd(ra(3, `MMP_OFF_CTL));
      chk("ctl mask", rq, `MMP_MASK_CTL);
      wr(ra(3, `MMP_OFF_PER), 32'hffff_ffff);
      rd(ra(3, `MMP_OFF_PER));
      chk("period mask", rq, 36'h0_0000_1fff);
      wr(ra(7, `MMP_OFF_THR), 32'h1234_5678);
      rd(ra(7, `MMP_OFF_THR));
      chk("thr ch7", rq, 36'h0_0000_1678);
      rd(ra(6, `MMP_OFF_THR));
      chk("thr ch6", rq, 36'h0_0000_0000);
      rd(12'h300);
      chk("unmapped", {3'h0, re, rq}, 36'h1_0000_0000);
      $display("registers done");
    end
  endtask

  task t_old;
    begin
      wr(ra(0, `MMP_OFF_CTL), 32'h0000_8000);
      wr(ra(0, `MMP_OFF_PER), 32'h0000_0004);
      wr(ra(0, `MMP_OFF_THR), 32'h0000_0001);
      wr(ra(0, `MMP_OFF_REP), 32'h0000_0002);
      wr(`MMP_OFF_ENABLE, 32'h0000_0001);
      run_len(0, 1'b1, n1);
      chk("old high", n1, 2);
      run_len(0, 1'b0, n2);
      chk("old low", n2, 4);
      run_len(0, 1'b1, n1);
      repeat (40) @(posedge sys_clk);
      chk("old finished", pwm_out[0], 1'b0);
      wr(`MMP_OFF_ENABLE, 32'h0000_0000);
      wr(ra(0, `MMP_OFF_CTL), 32'h0000_8080);
      repeat (4) @(posedge sys_clk);
      chk("idle level", pwm_out[0], 1'b1);
      $display("old mode done");
    end
  endtask

  task t_fifo;
    begin
      wr(ra(1, `MMP_OFF_CTL), 32'h0000_0400);
      wr(ra(1, `MMP_OFF_HDUR), 32'h0000_0002);
      wr(ra(1, `MMP_OFF_LDUR), 32'h0000_0003);
      wr(ra(1, `MMP_OFF_GDUR), 32'h0000_0005);
      wr(ra(1, `MMP_OFF_WLO), 32'h0000_0005);
      wr(ra(1, `MMP_OFF_REP), 32'h0000_0002);
      wr(`MMP_OFF_ENABLE, 32'h0000_0002);
      run_len(1, 1'b1, n1);
      chk("bit high", n1, 2);
      run_len(1, 1'b0, n2);
      chk("bit low", n2, 3);
      run_len(1, 1'b1, n1);
      run_len(1, 1'b0, n2);
      chk("last bit gap", n1 + n2, 8);
      repeat (40) @(posedge sys_clk);
      chk("fifo finished", pwm_out[1], 1'b0);
      $display("fifo mode done");
    end
  endtask

  task t_mem;
    begin
      lat <= 8'h06;
      wr(ra(2, `MMP_OFF_CTL), 32'h0000_0020);
      wr(ra(2, `MMP_OFF_HDUR), 32'h0000_0003);
      wr(ra(2, `MMP_OFF_B0), 32'h0000_0100);
      wr(ra(2, `MMP_OFF_B0EXT), 32'h0000_0001);
      wr(ra(2, `MMP_OFF_B0LEN), 32'h0000_0001);
      wr(ra(2, `MMP_OFF_REP), 32'h0000_0001);
      wr(`MMP_OFF_ENABLE, 32'h0000_0004);
      wait_req;
      chk("fetch addr", mem_addr, 36'h1_0000_0100);
      run_len(2, 1'b1, n1);
      chk("mem bit", n1, 3);
      rd(ra(2, `MMP_OFF_WLO));
      chk("fetch buffer", rq, 36'h0_0000_0101);
      $display("memory mode done");
    end
  endtask

  task t_rand;
    begin
      lat <= 8'h00;
      wr(ra(4, `MMP_OFF_CTL), 32'h0000_0060);
      wr(ra(4, `MMP_OFF_B0), 32'h0000_0200);
      wr(ra(4, `MMP_OFF_B1), 32'h0000_0300);
      wr(ra(4, `MMP_OFF_VALID), 32'h0000_0001);
      wr(`MMP_OFF_ENABLE, 32'h0000_0010);
      n1 = 0;
      while (pwm_underflow[4] !== 1'b1 && n1 < 2000)
      begin
        @(posedge sys_clk);
        n1 = n1 + 1;
      end
      hang(n1);
      rd(ra(4, `MMP_OFF_VALID));
      chk("valid drained", rq, 36'h0_0000_0000);
      chk("stopped", pwm_out[4], 1'b0);
      wr(`MMP_OFF_ENABLE, 32'h0000_0000);
      wr(ra(4, `MMP_OFF_VALID), 32'h0000_0003);
      wr(`MMP_OFF_ENABLE, 32'h0000_0010);
      wait_req;
      chk("buf0 addr", mem_addr, 36'h0_0000_0200);
      chk("underflow clr", pwm_underflow[4], 1'b0);
      wait_req;
      chk("buf1 addr", mem_addr, 36'h0_0000_0300);
      wr(`MMP_OFF_ENABLE, 32'h0000_0000);
      $display("random mode done");
    end
  endtask

  // reset, then every scenario in turn
  initial
  begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs;
    t_old;
    t_fifo;
    t_mem;
    t_rand;
    stop_test;
  end
endmodule // mmp_pwm_tb
